// [logic/phyic_pkg.sv]
// Constants, offsets and types for the PHY init, strap and power control block.
// Assumes a 100 MHz pclk; the blackout and sleep cycle counts below derive from CLK_MHZ.
package phyic_pkg;
   // Timing
   localparam int CLK_MHZ       = 100;
   localparam int BLACKOUT_US   = 1000;
   localparam int BLACKOUT_CYC  = BLACKOUT_US * CLK_MHZ;
   localparam int SLP0_MS       = 1000;
   localparam int SLP1_MS       = 2000;
   localparam int SLP2_MS       = 3040;
   localparam int SLP0_CYC      = SLP0_MS * CLK_MHZ * 1000;
   localparam int SLP1_CYC      = SLP1_MS * CLK_MHZ * 1000;
   localparam int SLP2_CYC      = SLP2_MS * CLK_MHZ * 1000;
   localparam int STRAP_CAP_CYC = 4;
   localparam int SWRST_CYC     = 16;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ADV  = 8'h04;
   localparam logic [7:0] OFS_CFG  = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // Control register fields
   localparam int CTL_RST  = 15;
   localparam int CTL_SPD  = 13;
   localparam int CTL_ANEG = 12;
   localparam int CTL_PD   = 11;
   localparam int CTL_FDX  = 8;
   // Advertisement register fields
   localparam int ADV_TXF  = 8;
   localparam int ADV_TX   = 7;
   localparam int ADV_10F  = 6;
   localparam int ADV_10   = 5;
   // Configuration register fields
   localparam int CFG_SLP     = 6;
   localparam int CFG_TSEL_HI = 4;
   localparam int CFG_TSEL_LO = 3;
   localparam int CFG_FIB     = 0;
   // Reset values
   localparam logic [15:0] CTL_RST_VAL    = 16'h0000;
   localparam logic [15:0] ADV_RST_VAL    = 16'h0001;
   localparam logic [15:0] CFG_RST_VAL    = 16'h0010;
   localparam logic [3:0]  ADV_FORCED_VAL = 4'hf;

   typedef enum logic [2:0] {
      LM_ANEG = 3'h0,
      LM_FX   = 3'h1,
      LM_10H  = 3'h2,
      LM_10F  = 3'h3,
      LM_100H = 3'h4,
      LM_100F = 3'h5
   } phyic_mode_t;

   typedef enum logic [3:0] {
      ST_BLACK = 4'h1,
      ST_RUN   = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE  = 4'h8
   } phyic_state_t;
endpackage

// [logic/phyic_sync.sv]
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; no bus coherency is kept across bits.
`timescale 1ns/1ps
`default_nettype none
module phyic_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Levels
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= '0;
         dout   <= '0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule // phyic_sync
`default_nettype wire

// [logic/phyic_init.sv]
// PHY initialisation: strap capture, control mode, power-down, sleep and resets.
// Assumes an APB3 master on pclk; all pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module phyic_init
   import phyic_pkg::*;
#(
   parameter int BLACKOUT_CYCLES = BLACKOUT_CYC,
   parameter int SLP0_CYCLES     = SLP0_CYC,
   parameter int SLP1_CYCLES     = SLP1_CYC,
   parameter int SLP2_CYCLES     = SLP2_CYC
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // Pins
   input  wire logic        hw_power_down_pin,
   input  wire logic        mgmt_disable_pin,
   input  wire logic [2:0]  led_strap_pins,
   input  wire logic        sleep_pin,
   input  wire logic        fiber_pin,
   input  wire logic        energy_pin,
   input  wire logic        link_up_pin,
   input  wire logic        link_fail_pin,
   // Port control
   output var  logic        port_enable,
   output var  logic        port_clk_enable,
   output var  logic        outputs_hiz,
   output var  logic        pulls_enable,
   output var  logic        link_start,
   output var  logic        aneg_start,
   output var  logic [2:0]  link_mode,
   output var  logic        sleeping
);
   localparam int SWRST_BOUND = 20;

   typedef struct packed {
      phyic_state_t st;
      logic [31:0]  cnt;
      logic [4:0]   strap;
      logic [15:0]  ctl;
      logic [15:0]  adv;
      logic [15:0]  cfg;
      logic [4:0]   rcnt;
      logic         fail_d;
      logic [31:0]  rdata;
      logic         ready;
      logic         slverr;
      logic         port_en;
      logic         clk_en;
      logic         hiz;
      logic         pull_en;
      logic         link_go;
      logic         aneg_go;
      phyic_mode_t  mode;
      logic         sleeping;
   } phyic_regs_t;

   localparam phyic_regs_t Q_RST = '{st: ST_BLACK, mode: LM_ANEG, default: '0};

   phyic_regs_t q;
   phyic_regs_t d;
   logic [9:0]  pins_s;
   logic [2:0]  strap_s;
   logic        pd_s;
   logic        md_s;
   logic        slp_s;
   logic        fib_s;
   logic        energy_s;
   logic        link_s;
   logic        fail_s;
   logic        setup;
   logic        acc;
   logic        blk;
   logic        fiber;
   logic        slp_en;
   logic [31:0] tmo;

   phyic_sync #(.W(10)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     ({link_fail_pin, link_up_pin, energy_pin, fiber_pin, sleep_pin,
                 mgmt_disable_pin, hw_power_down_pin, led_strap_pins}),
      .dout    (pins_s)
   );

   assign strap_s  = pins_s[2:0];
   assign pd_s     = pins_s[3];
   assign md_s     = pins_s[4];
   assign slp_s    = pins_s[5];
   assign fib_s    = pins_s[6];
   assign energy_s = pins_s[7];
   assign link_s   = pins_s[8];
   assign fail_s   = pins_s[9];

   function automatic logic [15:0] f_ctl(input logic [2:0] s);
      logic [15:0] r;
      r           = CTL_RST_VAL;
      r[CTL_ANEG] = s[0];
      r[CTL_SPD]  = s[0] | s[1];
      r[CTL_FDX]  = s[2];
      return r;
   endfunction

   function automatic logic [15:0] f_adv(input logic [2:0] s);
      logic [15:0] r;
      r = ADV_RST_VAL;
      if (s[0])
      begin
         r[ADV_TXF] = s[2];
         r[ADV_TX]  = 1'b1;
         r[ADV_10F] = s[1] & s[2];
         r[ADV_10]  = s[1];
      end
      else
      begin
         r[ADV_TXF:ADV_10] = ADV_FORCED_VAL;
      end
      return r;
   endfunction

   function automatic logic [15:0] f_cfg(input logic slp, input logic fib);
      logic [15:0] r;
      r          = CFG_RST_VAL;
      r[CFG_SLP] = slp;
      r[CFG_FIB] = fib;
      return r;
   endfunction

   function automatic phyic_mode_t f_mode(input logic [15:0] c, input logic fib);
      phyic_mode_t m;
      if (fib)
         m = LM_FX;
      else if (c[CTL_ANEG])
         m = LM_ANEG;
      else
         case ({c[CTL_SPD], c[CTL_FDX]})
            2'h0:    m = LM_10H;
            2'h1:    m = LM_10F;
            2'h2:    m = LM_100H;
            default: m = LM_100F;
         endcase
      return m;
   endfunction

   assign setup  = psel & ~penable;
   assign acc    = psel & penable & q.ready;
   assign blk    = (q.st == ST_BLACK)
                   | pd_s
                   | md_s;
   assign fiber  = md_s ? fib_s : q.cfg[CFG_FIB];
   assign slp_en = (md_s ? slp_s : q.cfg[CFG_SLP])
                   & ~fiber;
   assign tmo    = (q.cfg[CFG_TSEL_HI:CFG_TSEL_LO] == 2'h0) ? 32'(SLP0_CYCLES) :
                   (q.cfg[CFG_TSEL_HI:CFG_TSEL_LO] == 2'h1) ? 32'(SLP1_CYCLES) :
                   32'(SLP2_CYCLES);

   always_comb
   begin
      logic restart;
      restart   = 1'b0;
      d         = q;
      d.link_go = 1'b0;
      d.aneg_go = 1'b0;
      // Answer registered in the setup cycle, so every access has zero wait states
      d.ready   = setup;
      d.slverr  = setup & blk;
      d.rdata   = 32'h0;
      if (setup & ~blk)
      begin
         case (paddr)
            OFS_CTRL: d.rdata = {16'h0, q.ctl};
            OFS_ADV:  d.rdata = {16'h0, q.adv};
            OFS_CFG:  d.rdata = {16'h0, q.cfg};
            OFS_STAT: d.rdata = {19'h0, q.strap, q.port_en, q.mode, q.st};
            default:  d.slverr = 1'b1;
         endcase
      end
      // Pin-control mode and power-down refuse writes at setup already
      if (acc & pwrite & ~q.slverr & ~blk)
      begin
         case (paddr)
            OFS_CTRL:
            begin
               d.ctl          = pwdata[15:0];
               d.ctl[CTL_RST] = pwdata[CTL_RST] | (q.rcnt != 5'h0);
               if (pwdata[CTL_RST])
                  d.rcnt = 5'(SWRST_CYC);
               restart = 1'b1;
            end
            OFS_ADV: d.adv = pwdata[15:0];
            OFS_CFG: d.cfg = pwdata[15:0];
            default: d.cfg = q.cfg;
         endcase
      end
      // Soft reset completion; restore wins over a write landing in the same cycle
      if (q.rcnt != 5'h0)
      begin
         d.rcnt = q.rcnt - 5'h1;
         if (q.rcnt == 5'h1)
         begin
            d.ctl   = f_ctl(q.strap[2:0]);
            d.adv   = f_adv(q.strap[2:0]);
            d.cfg   = f_cfg(q.strap[3], q.strap[4]);
            restart = 1'b1;
         end
      end
      d.fail_d = fail_s;
      if (fail_s & ~q.fail_d)
         restart = 1'b1;
      case (q.st)
         ST_BLACK:
         begin
            d.cnt = q.cnt + 32'h1;
            // Straps are read only after the synchroniser has settled
            if (q.cnt == 32'(STRAP_CAP_CYC))
            begin
               d.strap = {fib_s, slp_s, strap_s};
               d.ctl   = f_ctl(strap_s);
               d.adv   = f_adv(strap_s);
               d.cfg   = f_cfg(slp_s, fib_s);
            end
            if (q.cnt >= 32'(BLACKOUT_CYCLES - 1))
            begin
               d.st    = ST_RUN;
               d.cnt   = 32'h0;
               restart = 1'b1;
            end
         end
         ST_RUN:
         begin
            if (energy_s)
               d.cnt = 32'h0;
            else if (q.cnt != 32'hffffffff)
               d.cnt = q.cnt + 32'h1;
            if (slp_en & ~energy_s & (q.cnt >= tmo))
            begin
               d.st  = ST_SLEEP;
               d.cnt = 32'h0;
            end
         end
         ST_SLEEP:
         begin
            if (~slp_en)
            begin
               d.st    = ST_RUN;
               restart = 1'b1;
            end
            else if (energy_s)
            begin
               d.st    = ST_WAKE;
               d.cnt   = 32'h0;
               restart = 1'b1;
            end
         end
         ST_WAKE:
         begin
            // Energy persists while looking for link, so it does not restart this count
            d.cnt = q.cnt + 32'h1;
            if (~slp_en | link_s)
            begin
               d.st  = ST_RUN;
               d.cnt = 32'h0;
            end
            else if (q.cnt >= tmo)
            begin
               d.st  = ST_SLEEP;
               d.cnt = 32'h0;
            end
         end
         default:
         begin
            d.st  = ST_BLACK;
            d.cnt = 32'h0;
         end
      endcase
      if (restart & (d.st != ST_BLACK))
      begin
         d.link_go = 1'b1;
         d.mode    = f_mode(d.ctl, fiber);
         d.aneg_go = d.ctl[CTL_ANEG] & ~fiber;
      end
      d.port_en  = ((d.st == ST_RUN) | (d.st == ST_WAKE)) & ~pd_s & ~d.ctl[CTL_PD]
                   & (d.rcnt == 5'h0);
      d.clk_en   = ~pd_s;
      d.hiz      = pd_s;
      d.pull_en  = ~pd_s;
      d.sleeping = d.st == ST_SLEEP;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= Q_RST;
      else
         q <= d;
   end

   assign prdata          = q.rdata;
   assign pready          = q.ready;
   assign pslverr         = q.slverr;
   assign port_enable     = q.port_en;
   assign port_clk_enable = q.clk_en;
   assign outputs_hiz     = q.hiz;
   assign pulls_enable    = q.pull_en;
   assign link_start      = q.link_go;
   assign aneg_start      = q.aneg_go;
   assign link_mode       = q.mode;
   assign sleeping        = q.sleeping;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_BLACKOUT_REFUSE: assert property (
      (setup && q.st == ST_BLACK) |=> (pslverr && pready && prdata == 32'h0))
      else $error("access during blackout not refused");
   AST_PD_REFUSE: assert property (
      (setup && pd_s) |=> pslverr)
      else $error("access during power-down not refused");
   AST_PD_OUTS: assert property (
      pd_s |=> (outputs_hiz && !pulls_enable && !port_enable && !port_clk_enable))
      else $error("power-down did not stop port and outputs");
   AST_HW_NOWRITE: assert property (
      (setup && pwrite && md_s && paddr == OFS_CTRL) ##1 acc |=> $stable(q.ctl) || $past(q.rcnt) == 5'h1)
      else $error("write accepted in pin-control mode");
   AST_MD_NOREAD: assert property (
      (setup && !pwrite && md_s) |=> (pslverr && prdata == 32'h0))
      else $error("read not blocked by management disable");
   AST_SWPD_PORT: assert property (
      (q.ctl[CTL_PD] && q.st != ST_BLACK && !pd_s && !md_s && setup && paddr == OFS_CTRL)
      |=> (!pslverr && !port_enable))
      else $error("soft power-down wrong");
   AST_SWRST_DONE: assert property (
      $rose(q.rcnt != 5'h0) |-> q.ctl[CTL_RST] ##[1:SWRST_BOUND] !q.ctl[CTL_RST])
      else $error("soft reset bit did not clear");
   AST_SWRST_RESTORE: assert property (
      $fell(q.rcnt != 5'h0) |-> (q.adv == f_adv(q.strap[2:0]) && q.ctl == f_ctl(q.strap[2:0])))
      else $error("soft reset did not restore latched straps");
   AST_STRAP_CTL: assert property (
      (q.st == ST_BLACK ##1 q.st == ST_RUN) |-> (q.ctl[CTL_ANEG] == q.strap[0]
         && q.ctl[CTL_SPD] == (q.strap[0] | q.strap[1]) && q.ctl[CTL_FDX] == q.strap[2]))
      else $error("control bits differ from straps");
   AST_STRAP_ADV: assert property (
      (q.st == ST_BLACK ##1 q.st == ST_RUN) |->
         ((q.strap[2:0] != 3'h1 || q.adv[8:5] == 4'h4) && (q.strap[2:0] != 3'h5 || q.adv[8:5] == 4'hc)
         && (q.strap[2:0] != 3'h3 || q.adv[8:5] == 4'h5) && (q.strap[2:0] != 3'h7 || q.adv[8:5] == 4'hf)))
      else $error("advertisement bits differ from straps");
   AST_START_AFTER_BLACKOUT: assert property (
      (q.st == ST_BLACK ##1 q.st == ST_RUN) |-> link_start)
      else $error("no link start after reset");
   AST_FORCED_NO_ANEG: assert property (
      (link_start && link_mode != LM_ANEG) |-> !aneg_start)
      else $error("negotiation started in forced mode");
   AST_SLEEP_ACCESS: assert property (
      (setup && sleeping && !pd_s && !md_s && paddr == OFS_STAT) |=> !pslverr)
      else $error("access refused while sleeping");
   AST_FIBER_NOSLEEP: assert property (
      fiber |=> !sleeping)
      else $error("sleep in fiber mode");
   AST_WAKE: assert property (
      (q.st == ST_SLEEP && slp_en && energy_s) |=> (q.st == ST_WAKE && link_start))
      else $error("no wake on energy");
   AST_ENERGY_RESTART: assert property (
      (q.st == ST_RUN && energy_s) |=> (q.cnt == 32'h0 && q.st == ST_RUN))
      else $error("timer not restarted by energy");
endmodule // phyic_init
`default_nettype wire

// [verification/phyic_mgr.sv]
// Station manager model: an APB master that the bench drives through tasks.
// Assumes pclk comes from the bench and that only one task runs at a time.
`timescale 1ns/1ps
`default_nettype none
module phyic_mgr (
   // Clock
   input  wire logic        pclk,
   // APB master side
   output var  logic [7:0]  paddr,
   output var  logic        psel,
   output var  logic        penable,
   output var  logic        pwrite,
   output var  logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   // Transfers whose answer missed the first access cycle; the bench checks it stays zero
   int late;

   initial
   begin
      paddr = 8'h00;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      pwdata = 32'h0;
   end

   // Holds the request until pready is seen; released lines are inverted so stale data never matches
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'h1 && n < 50);
      if (n != 1)
         late++;
      rd = prdata[15:0];
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      paddr <= ~a;
      pwdata <= ~{16'h0, d};
   endtask

   // Registers stay closed after reset release; keep asking until one is accepted
   task automatic wait_open();
      logic [15:0] rd;
      logic        err;
      err = 1'h1;
      for (int i = 0; i < 100 && err !== 1'h0; i++)
         xfer(1'h0, 8'h14, 16'h0, rd, err);
   endtask

   // Soft reset completion is seen by polling the self-clearing bit
   task automatic poll_rst(output logic busy, output logic done);
      logic [15:0] rd;
      logic        err;
      busy = 1'h0;
      done = 1'h0;
      for (int i = 0; i < 40 && done !== 1'h1; i++)
      begin
         xfer(1'h0, 8'h00, 16'h0, rd, err);
         if (rd[15] === 1'h1)
            busy = 1'h1;
         else if (err === 1'h0)
            done = 1'h1;
      end
   endtask
endmodule // phyic_mgr
`default_nettype wire

// [verification/phy_init_power_reset_config_bench.sv]
// Testbench for the init, strap, power and reset block.
// Assumes shortened blackout and sleep counts; the manager model speaks APB.
`timescale 1ns/1ps
`default_nettype none
module phy_init_power_reset_config_bench
   import phyic_pkg::*;
();
   localparam int BLK = 50;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        hw_power_down_pin, mgmt_disable_pin, sleep_pin, fiber_pin;
   logic        energy_pin, link_up_pin, link_fail_pin;
   logic [2:0]  led_strap_pins, link_mode, last_mode, s, s0;
   logic        port_enable, port_clk_enable, outputs_hiz, pulls_enable;
   logic        link_start, aneg_start, sleeping, last_aneg, err, busy, done;
   logic [15:0] rd, c;
   int          failures, num_checks, cyc, ls_cnt, l0, t0;
   logic [31:0] r;

   phyic_init #(.BLACKOUT_CYCLES(BLK), .SLP0_CYCLES(20), .SLP1_CYCLES(30), .SLP2_CYCLES(40)) i_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .hw_power_down_pin, .mgmt_disable_pin, .led_strap_pins, .sleep_pin, .fiber_pin,
      .energy_pin, .link_up_pin, .link_fail_pin, .port_enable, .port_clk_enable, .outputs_hiz,
      .pulls_enable, .link_start, .aneg_start, .link_mode, .sleeping);
   phyic_mgr i_mgr (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);

   always #5 pclk = ~pclk;

   // Records every link (re)start with the mode it carried
   always @(posedge pclk)
   begin
      cyc++;
      if (link_start === 1'h1)
      begin
         ls_cnt++;
         last_mode = link_mode;
         last_aneg = aneg_start;
      end
      if (cyc == 20000)
      begin
         failures++;
         close_out();
      end
   end

   task automatic close_out();
      if (failures == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rdr(input logic [7:0] a);
      i_mgr.xfer(1'h0, a, 16'h0, rd, err);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_mgr.xfer(1'h1, a, d, rd, err);
   endtask

   task automatic waitfor(input logic v, input int n);
      for (int i = 0; i < n && sleeping !== v; i++)
         @(posedge pclk);
      chk(sleeping, v);
   endtask

   function automatic logic [15:0] exp_ctrl(input logic [2:0] p);
      logic [15:0] x;
      x = 16'h0;
      x[CTL_ANEG] = p[0];
      x[CTL_SPD] = p[0] | p[1];
      x[CTL_FDX] = p[2];
      return x;
   endfunction

   function automatic logic [15:0] exp_adv(input logic [2:0] p);
      logic [15:0] x;
      x = 16'h0001;
      x[ADV_TXF] = !p[0] | p[2];
      x[ADV_TX] = 1'h1;
      x[ADV_10F] = !p[0] | (p[1] & p[2]);
      x[ADV_10] = !p[0] | p[1];
      return x;
   endfunction

   function automatic logic [2:0] exp_mode(input logic [15:0] x);
      return x[CTL_ANEG] ? LM_ANEG : 3'h2 + {1'h0, x[CTL_SPD], x[CTL_FDX]};
   endfunction

   initial
   begin
      pclk = 1'h0;
      presetn = 1'h0;
      {hw_power_down_pin, mgmt_disable_pin, sleep_pin, fiber_pin, link_up_pin, link_fail_pin} = 6'h0;
      energy_pin = 1'h1;
      led_strap_pins = 3'h0;
      r = $urandom(16251);
      r = $urandom;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge pclk);
         s = 3'(i) ^ r[2:0];
         led_strap_pins <= s;
         presetn <= 1'h0;
         repeat (3) @(posedge pclk);
         presetn <= 1'h1;
         t0 = cyc;
         l0 = ls_cnt;
         rdr(OFS_STAT);
         chk(err, 1'h1);
         i_mgr.wait_open();
         chk(cyc - t0 > BLK, 1'h1);
         rdr(OFS_CTRL);
         chk(rd, exp_ctrl(s));
         rdr(OFS_ADV);
         chk(rd, exp_adv(s));
         chk(ls_cnt - l0, 1);
         chk({last_aneg, last_mode}, {s[0], exp_mode(exp_ctrl(s))});
      end
      s0 = s;
      rdr(8'h08);
      chk({err, rd}, {1'h1, 16'h0});
      for (int i = 0; i < 8; i++)
      begin
         r = $urandom;
         c = 16'h0;
         c[CTL_SPD] = i[0] ^ r[0];
         c[CTL_ANEG] = i[1] ^ r[1];
         c[CTL_FDX] = i[2] ^ r[2];
         wr(OFS_CTRL, c);
         repeat (3) @(posedge pclk);
         rdr(OFS_CTRL);
         chk(rd, c);
         chk({last_aneg, last_mode}, {c[CTL_ANEG], exp_mode(c)});
      end
      wr(OFS_CTRL, 16'h0800);
      repeat (3) @(posedge pclk);
      rdr(OFS_CTRL);
      chk({port_enable, rd}, {1'h0, 16'h0800});
      wr(OFS_CTRL, 16'h0000);
      repeat (3) @(posedge pclk);
      chk(port_enable, 1'h1);
      mgmt_disable_pin <= 1'h1;
      repeat (4) @(posedge pclk);
      wr(OFS_CTRL, 16'h0800);
      chk(err, 1'h1);
      rdr(OFS_CTRL);
      chk(err, 1'h1);
      mgmt_disable_pin <= 1'h0;
      repeat (4) @(posedge pclk);
      rdr(OFS_CTRL);
      chk({err, rd}, 17'h0);
      hw_power_down_pin <= 1'h1;
      repeat (5) @(posedge pclk);
      chk({port_enable, port_clk_enable, outputs_hiz, pulls_enable}, 4'h2);
      rdr(OFS_CTRL);
      chk(err, 1'h1);
      hw_power_down_pin <= 1'h0;
      repeat (5) @(posedge pclk);
      chk({port_enable, port_clk_enable, outputs_hiz, pulls_enable}, 4'hd);
      l0 = ls_cnt;
      link_fail_pin <= 1'h1;
      repeat (6) @(posedge pclk);
      chk(ls_cnt - l0, 1);
      link_fail_pin <= 1'h0;
      wr(OFS_CFG, 16'h0040);
      energy_pin <= 1'h0;
      repeat (15) @(posedge pclk);
      energy_pin <= 1'h1;
      repeat (3) @(posedge pclk);
      energy_pin <= 1'h0;
      repeat (15) @(posedge pclk);
      chk(sleeping, 1'h0);
      waitfor(1'h1, 20);
      rdr(OFS_STAT);
      chk({err, rd[3:0]}, 5'h04);
      l0 = ls_cnt;
      energy_pin <= 1'h1;
      waitfor(1'h0, 6);
      repeat (2) @(posedge pclk);
      chk(ls_cnt - l0, 1);
      energy_pin <= 1'h0;
      waitfor(1'h1, 40);
      energy_pin <= 1'h1;
      link_up_pin <= 1'h1;
      waitfor(1'h0, 6);
      repeat (3) @(posedge pclk);
      rdr(OFS_STAT);
      chk(rd[3:0], 4'h2);
      link_up_pin <= 1'h0;
      wr(OFS_CFG, 16'h0000);
      sleep_pin <= 1'h1;
      energy_pin <= 1'h0;
      repeat (40) @(posedge pclk);
      chk(sleeping, 1'h0);
      wr(OFS_CFG, 16'h0041);
      repeat (40) @(posedge pclk);
      chk(sleeping, 1'h0);
      mgmt_disable_pin <= 1'h1;
      waitfor(1'h1, 10);
      fiber_pin <= 1'h1;
      waitfor(1'h0, 6);
      {mgmt_disable_pin, fiber_pin} <= 2'h0;
      repeat (4) @(posedge pclk);
      energy_pin <= 1'h1;
      sleep_pin <= 1'h0;
      wr(OFS_CTRL, 16'h1000);
      repeat (3) @(posedge pclk);
      chk({last_aneg, last_mode}, {1'h0, LM_FX});
      led_strap_pins <= ~s0;
      wr(OFS_ADV, 16'h0000);
      wr(OFS_CTRL, 16'h8000);
      i_mgr.poll_rst(busy, done);
      chk({busy, done}, 2'h3);
      rdr(OFS_CTRL);
      chk(rd, exp_ctrl(s0));
      rdr(OFS_ADV);
      chk(rd, exp_adv(s0));
      rdr(OFS_CFG);
      chk(rd, CFG_RST_VAL);
      chk(i_mgr.late, 0);
      close_out();
   end
endmodule // phy_init_power_reset_config_bench
`default_nettype wire
